/* dv/scss_bench.sv */
// Bench for the session sequencer: APB tasks and pin sequences.
// Assumes the card model in scss_card_model.sv.
`timescale 1ns/1ps
module scss_bench;
  import scss_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] vcc_select;
  logic supply_request_low_v_n, supply_request_high_v_n, card_reset_input;
  logic card_clock_input, chip_select, shutdown_ack, card_detect_input;
  logic overcurrent, vcc_in_range, card_type_route_select, hd, card_tx, er, supply_fail;
  logic host_data_line_i, host_data_line_o, host_data_line_oe_n;
  logic host_extra_line1_i, host_extra_line1_o, host_extra_line1_oe_n;
  logic host_extra_line2_i, host_extra_line2_o, host_extra_line2_oe_n;
  logic card_data_line_i, card_data_line_o, card_data_line_oe_n;
  logic card_extra_line1_i, card_extra_line1_o, card_extra_line1_oe_n;
  logic card_extra_line2_i, card_extra_line2_o, card_extra_line2_oe_n;
  logic card_rst, card_clk, vcc_enable, route_usb;
  logic fault_n_o, fault_n_oe_n, ready_o, ready_oe_n;
  int mismatches = 0;
  int n_tests = 0;
  int n;
  scss_top #(.CHK_CYC(2000)) uut (.*);
  scss_card_model card (.clk_sys(clk_sys), .vcc_enable(vcc_enable), .card_tx(card_tx),
    .supply_fail(supply_fail),
    .o({card_extra_line2_o, card_extra_line1_o, card_data_line_o}),
    .oe_n({card_extra_line2_oe_n, card_extra_line1_oe_n, card_data_line_oe_n}),
    .i({card_extra_line2_i, card_extra_line1_i, card_data_line_i}),
    .vcc_in_range(vcc_in_range));
  assign host_data_line_i = host_data_line_oe_n ? hd : host_data_line_o;
  assign host_extra_line1_i = host_extra_line1_oe_n ? 1'b1 : host_extra_line1_o;
  assign host_extra_line2_i = host_extra_line2_oe_n ? 1'b1 : host_extra_line2_o;
  task automatic cy(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rdy;
    for (n = 0; n < 1000 && ready_o !== 1'b1; n++) cy(1);
    chk(ready_o, 1'b1);
  endtask
  task automatic wait_off;
    for (n = 0; n < 300 && vcc_enable !== 1'b0; n++) cy(1);
    chk(vcc_enable, 1'b0);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #400us;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_request_low_v_n, supply_request_high_v_n, chip_select, hd, card_tx} = 5'h1F;
    {card_reset_input, card_clock_input, shutdown_ack, card_detect_input} = 4'h0;
    {overcurrent, card_type_route_select, supply_fail} = 3'h0;
    rst = 1;
    cy(3);
    rst <= 0;
    cy(6);
    chk({card_data_line_oe_n, card_data_line_o, host_data_line_oe_n}, 3'h1);
    chk({card_rst, card_clk, fault_n_o}, 3'h0);
    chk({card_extra_line1_oe_n, card_extra_line1_o, card_extra_line2_oe_n, card_extra_line2_o,
      host_extra_line1_oe_n, host_extra_line1_o, host_extra_line2_oe_n, host_extra_line2_o},
      8'h0F);
    apb(0, SCSS_OFF_T1, 0);
    chk(rd, 32'h28);
    apb(0, 8'h14, 0);
    chk(er, 1'b1);
    for (int k = 0; k < 4; k++) apb(1, 8'(4 * k), 32'h4);
    apb(0, SCSS_OFF_T4, 0);
    chk(rd, 32'h4);
    supply_request_low_v_n <= 0;
    cy(8);
    chk(vcc_enable, 1'b0);
    supply_request_low_v_n <= 1;
    card_detect_input <= 1;
    card_type_route_select <= 1;
    cy(8);
    chk({fault_n_o, route_usb}, 2'h3);
    supply_request_low_v_n <= 0;
    cy(6);
    chk(vcc_select, SCSS_V_3);
    chk({card_data_line_oe_n, card_data_line_o, card_rst}, 3'h0);
    wait_rdy;
    card_reset_input <= 1;
    card_clock_input <= 1;
    cy(8);
    chk({card_rst, card_clk}, 2'h3);
    repeat (4)
    begin
      card_clock_input <= ~card_clock_input;
      cy(4);
      chk(card_clk, card_clock_input);
    end
    hd <= 0;
    cy(6);
    chk({card_data_line_oe_n, card_data_line_o}, 2'h0);
    hd <= 1;
    cy(6);
    chk({card_data_line_oe_n, host_data_line_oe_n}, 2'h3);
    card_tx <= 0;
    cy(6);
    chk({host_data_line_oe_n, host_data_line_o}, 2'h0);
    card_tx <= 1;
    cy(6);
    chip_select <= 0;
    card_reset_input <= 0;
    hd <= 0;
    cy(8);
    chk({fault_n_oe_n, ready_oe_n}, 2'h3);
    chk({card_rst, card_data_line_oe_n, route_usb}, 3'h7);
    hd <= 1;
    chip_select <= 1;
    cy(6);
    supply_request_low_v_n <= 1;
    wait_off;
    chk({card_rst, card_clk, card_data_line_oe_n, card_data_line_o}, 4'h0);
    card_clock_input <= 0;
    cy(20);
    supply_request_high_v_n <= 0;
    cy(6);
    chk(vcc_select, SCSS_V_5);
    wait_rdy;
    overcurrent <= 1;
    cy(4);
    chk(fault_n_o, 1'b0);
    wait_off;
    overcurrent <= 0;
    supply_request_high_v_n <= 1;
    cy(20);
    {supply_request_low_v_n, supply_request_high_v_n} <= 2'h0;
    cy(6);
    chk(vcc_select, SCSS_V_18);
    shutdown_ack <= 1;
    cy(4);
    chk(fault_n_o, 1'b0);
    wait_off;
    shutdown_ack <= 0;
    {supply_request_low_v_n, supply_request_high_v_n} <= 2'h3;
    supply_fail <= 1;
    cy(20);
    supply_request_low_v_n <= 0;
    cy(1000);
    chk({vcc_enable, ready_o, fault_n_o}, 3'h5);
    cy(1010);
    chk(fault_n_o, 1'b0);
    wait_off;
    tally_and_finish;
  end
endmodule

/* dv/scss_card_model.sv */
// Card model: supply settles a few cycles after enable; card drives data on request.
// Assumes released card lines are pulled up.
`timescale 1ns/1ps
module scss_card_model
(
  input wire logic clk_sys,
  input wire logic vcc_enable,
  input wire logic card_tx,
  input wire logic supply_fail,
  input wire logic [2:0] o,
  input wire logic [2:0] oe_n,
  output logic [2:0] i,
  output logic vcc_in_range
);
  int cnt;
  always_ff @(posedge clk_sys)
  begin
    cnt <= vcc_enable ? cnt + 1 : 0;
  end
  assign vcc_in_range = cnt > 10 && !supply_fail;
  assign i = (~oe_n & o) | (oe_n & {2'h3, card_tx});
endmodule

/* inc/scss_line_if.sv */
// Control and pin signals of one host/card data line pair.
// Assumes the sequencer drives the control side and the arbiter the pins.
`timescale 1ns/1ps
interface scss_line_if;
  logic rx_en;
  logic pass_en;
  logic host_i;
  logic card_i;
  logic host_o;
  logic host_oe_n;
  logic card_o;
  logic card_oe_n;
  modport ctl (output rx_en, output pass_en, output host_i, output card_i,
    input host_o, input host_oe_n, input card_o, input card_oe_n);
  modport arb (input rx_en, input pass_en, input host_i, input card_i,
    output host_o, output host_oe_n, output card_o, output card_oe_n);
endinterface

/* inc/scss_pkg.sv */
// Constants, types and timing for the smart card session sequencer.
// Assumes a 40 MHz system clock; all pin inputs arrive asynchronously.
package scss_pkg;
  localparam int SCSS_CLK_MHZ = 40;
  localparam int SCSS_WIN_NS = 400;
  localparam int SCSS_WIN_CYC = SCSS_WIN_NS * SCSS_CLK_MHZ / 1000;
  localparam int SCSS_RDY_US = 20;
  localparam int SCSS_RDY_CYC = SCSS_RDY_US * SCSS_CLK_MHZ;
  localparam int SCSS_CHK_US = 510;
  localparam int SCSS_CHK_CYC = SCSS_CHK_US * SCSS_CLK_MHZ;
  localparam int SCSS_TW = 16;
  localparam int SCSS_AW = 8;
  localparam logic [15:0] SCSS_T_RST = 16'h0028;
  localparam logic [7:0] SCSS_OFF_T1 = 8'h00;
  localparam logic [7:0] SCSS_OFF_T2 = 8'h04;
  localparam logic [7:0] SCSS_OFF_T3 = 8'h08;
  localparam logic [7:0] SCSS_OFF_T4 = 8'h0C;
  localparam logic [7:0] SCSS_OFF_STATUS = 8'h10;
  localparam logic [2:0] SCSS_SEL_ST = 3'h4;
  localparam logic [2:0] SCSS_SEL_BAD = 3'h5;
  localparam logic [1:0] SCSS_V_NONE = 2'h0;
  localparam logic [1:0] SCSS_V_3 = 2'h1;
  localparam logic [1:0] SCSS_V_5 = 2'h2;
  localparam logic [1:0] SCSS_V_18 = 2'h3;
  localparam logic [1:0] SCSS_STEP_LAST = 2'h3;
  localparam logic [1:0] SCSS_STEP_IO = 2'h2;
  localparam logic [1:0] SCSS_STEP_CLK = 2'h1;
  localparam logic [1:0] SCSS_STEP_RST = 2'h0;

  typedef enum logic [1:0] {SCSS_ST_OFF, SCSS_ST_ACT, SCSS_ST_ON, SCSS_ST_DEACT} scss_state_t;
  typedef enum logic [1:0] {SCSS_DIR_IDLE, SCSS_DIR_HOST_IN, SCSS_DIR_CARD_IN} scss_dir_t;

  typedef struct packed {
    logic req_l_n;
    logic req_h_n;
    logic rst;
    logic clk;
    logic cs;
    logic off_ack;
    logic card_in;
    logic ovc;
    logic vcc_ok;
    logic route;
    logic [2:0] host;
    logic [2:0] card;
  } scss_pins_t;

  typedef struct packed {
    logic req_l_n;
    logic req_h_n;
    logic rst;
    logic clk;
  } scss_ctl_t;

  typedef struct packed {
    logic [17:0] pad;
    logic [1:0] step;
    logic [1:0] state;
    logic [1:0] vsel;
    logic ready;
    logic fault_n;
    logic card_in;
    logic rx_en;
    logic vcc_on;
    logic clk_en;
    logic rst_en;
    logic route;
  } scss_status_t;

  localparam scss_ctl_t SCSS_CTL_RST = '{req_l_n: 1'h1, req_h_n: 1'h1, default: 1'h0};
  localparam scss_pins_t SCSS_PINS_RST = '{req_l_n: 1'h1, req_h_n: 1'h1, cs: 1'h1,
    host: 3'h7, card: 3'h7, default: 1'h0};
endpackage

/* src/scss_line_arb.sv */
// Direction arbiter for one host/card data line pair.
// Assumes inputs already synchronised to clk_sys; released lines are pulled up.
`timescale 1ns/1ps
module scss_line_arb
  import scss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  scss_line_if.arb lp
);
  scss_dir_t dir_q, dir_d;
  logic host_prev_q;
  logic card_prev_q;
  logic host_fell, card_fell, host_rose, card_rose;

  assign host_fell = host_prev_q & ~lp.host_i;
  assign card_fell = card_prev_q & ~lp.card_i;
  assign host_rose = ~host_prev_q & lp.host_i;
  assign card_rose = ~card_prev_q & lp.card_i;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      host_prev_q <= 1'h1;
      card_prev_q <= 1'h1;
    end
    else
    begin
      host_prev_q <= lp.host_i;
      card_prev_q <= lp.card_i;
    end
  end

  always_comb
  begin
    dir_d = dir_q;
    if (!lp.rx_en || !lp.pass_en)
      dir_d = SCSS_DIR_IDLE; // RQ14
    else
    begin
      unique case (dir_q)
        SCSS_DIR_IDLE:
          if (host_fell)
            dir_d = SCSS_DIR_HOST_IN; // RQ18
          else if (card_fell)
            dir_d = SCSS_DIR_CARD_IN; // RQ18
        SCSS_DIR_HOST_IN:
          if (host_rose)
            dir_d = SCSS_DIR_IDLE; // RQ19
        SCSS_DIR_CARD_IN:
          if (card_rose)
            dir_d = SCSS_DIR_IDLE; // RQ19
        default:
          dir_d = SCSS_DIR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dir_q <= SCSS_DIR_IDLE;
    else
      dir_q <= dir_d;
  end

  // Card side held low until reception; host side released high
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lp.card_o <= 1'h0; // RQ17
      lp.card_oe_n <= 1'h0;
      lp.host_o <= 1'h1;
      lp.host_oe_n <= 1'h1;
    end
    else
    begin
      lp.card_o <= (dir_d == SCSS_DIR_HOST_IN) ? lp.host_i : 1'h0; // RQ1
      lp.card_oe_n <= lp.rx_en && (dir_d != SCSS_DIR_HOST_IN); // RQ17
      lp.host_o <= (dir_d == SCSS_DIR_CARD_IN) ? lp.card_i : 1'h1;
      lp.host_oe_n <= (dir_d != SCSS_DIR_CARD_IN); // RQ18
    end
  end

  sequence s_host_grab;
    dir_q == SCSS_DIR_IDLE && lp.rx_en && lp.pass_en && host_fell;
  endsequence

  AST_ARB_GRAB: assert property (@(posedge clk_sys) disable iff (rst) // RQ18
    s_host_grab |=> !lp.card_oe_n && !lp.card_o && lp.host_oe_n)
    else $error("host fall did not take the card line");
  AST_ARB_BLOCK: assert property (@(posedge clk_sys) disable iff (rst) // RQ14
    (!lp.pass_en && lp.rx_en) |=> lp.card_oe_n && lp.host_oe_n)
    else $error("data passed while select low");
  AST_ARB_NEUTRAL: assert property (@(posedge clk_sys) disable iff (rst) // RQ19
    (dir_q == SCSS_DIR_CARD_IN && card_rose && lp.rx_en) |=> lp.host_oe_n && lp.card_oe_n)
    else $error("lines not released on input rise");
endmodule

/* src/scss_top.sv */
// Smart card session sequencer: activation, deactivation, fault and line control.
// Assumes APB master on clk_sys; pins asynchronous; released lines pulled up outside.
//
// Contract
// RQ1: Card clock, reset, data and auxiliary lines stay low outside a session.
// RQ2: After a supply request falls, card lines stay low until ready rises.
// RQ3: Host keeps its line images low and still until ready is high.
// RQ4: Activation starts only with a card present and fault output high.
// RQ5: Deactivate on both requests high, on a fault, or on shutdown acknowledge.
// RQ6: Over-current, supply under-voltage and card removal are hardware faults.
// RQ7: Deactivation: reset low, then clock stop, then data low, then supply off.
// RQ8: Host clock goes to the card unshaped; last pulse may be short.
// RQ9: Outside a session the fault output shows card presence only; a latched fault holds it low until both requests are high when off.
// RQ10: In a session a fault drops the fault output and starts deactivation together.
// RQ11: Host stops toggling its lines once the fault output falls in session.
// RQ12: Select high lets the control inputs act and data lines pass.
// RQ13: Select falling captures reset, request and clock inputs until it rises.
// RQ14: Select low blocks all data transfer between host and card lines.
// RQ15: Select low releases the fault and ready outputs to high impedance.
// RQ16: Select never affects fault sensing, card detect or card type routing.
// RQ17: After reset card data lines are low and host data lines high.
// RQ18: First falling data line becomes input; the other is driven as output.
// RQ19: A rise on the input line returns both lines to neutral idle.
// RQ20: Request falls choose voltage; both within the window choose the lowest.
// RQ21: Ready rises after supply stays in range for the settle time.
// RQ22: At the check time a low ready forces emergency deactivation.
// RQ23: Deactivation step intervals are software-set cycle counts.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module scss_top
  import scss_pkg::*;
#(
  parameter int CHK_CYC = SCSS_CHK_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SCSS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_request_low_v_n,
  input wire logic supply_request_high_v_n,
  input wire logic card_reset_input,
  input wire logic card_clock_input,
  input wire logic chip_select,
  input wire logic shutdown_ack,
  input wire logic card_detect_input,
  input wire logic overcurrent,
  input wire logic vcc_in_range,
  input wire logic card_type_route_select,
  input wire logic host_data_line_i,
  output logic host_data_line_o,
  output logic host_data_line_oe_n,
  input wire logic host_extra_line1_i,
  output logic host_extra_line1_o,
  output logic host_extra_line1_oe_n,
  input wire logic host_extra_line2_i,
  output logic host_extra_line2_o,
  output logic host_extra_line2_oe_n,
  input wire logic card_data_line_i,
  output logic card_data_line_o,
  output logic card_data_line_oe_n,
  input wire logic card_extra_line1_i,
  output logic card_extra_line1_o,
  output logic card_extra_line1_oe_n,
  input wire logic card_extra_line2_i,
  output logic card_extra_line2_o,
  output logic card_extra_line2_oe_n,
  output logic card_rst,
  output logic card_clk,
  output logic vcc_enable,
  output logic [1:0] vcc_select,
  output logic route_usb,
  output logic fault_n_o,
  output logic fault_n_oe_n,
  output logic ready_o,
  output logic ready_oe_n
);
  localparam int CW = $clog2(CHK_CYC + 1);
  localparam int RW = $clog2(SCSS_RDY_CYC + 1);
  localparam int WW = $clog2(SCSS_WIN_CYC + 1);

  if (CHK_CYC <= SCSS_WIN_CYC)
  begin : g_chk
    $error("CHK_CYC too small");
  end

  function automatic logic [2:0] reg_sel(input logic [SCSS_AW-1:0] a);
    unique case (a)
      SCSS_OFF_T1: reg_sel = 3'h0;
      SCSS_OFF_T2: reg_sel = 3'h1;
      SCSS_OFF_T3: reg_sel = 3'h2;
      SCSS_OFF_T4: reg_sel = 3'h3;
      SCSS_OFF_STATUS: reg_sel = SCSS_SEL_ST;
      default: reg_sel = SCSS_SEL_BAD;
    endcase
  endfunction

  scss_pins_t pin_raw, s1_q, s2_q;
  scss_ctl_t hold_q, eff;
  scss_state_t st_q, st_d;
  logic req_l_prev_q, req_h_prev_q;
  logic fall_l, fall_h, rel, in_session, fault_ev, chk_hit, chk_fail, deact_go, start;
  logic step_done;
  logic [CW-1:0] chk_cnt_q;
  logic [RW-1:0] rdy_cnt_q;
  logic [WW-1:0] win_q;
  logic [SCSS_TW-1:0] dcnt_q;
  logic [1:0] step_q;
  logic [SCSS_TW-1:0] t_q [4];
  logic ready_q, vcc_on_q, rst_en_q, clk_en_q, rx_en_q, fault_q;
  logic fault_n_q, fault_oe_n_q, ready_oe_n_q, card_rst_q, card_clk_q, route_q;
  logic [1:0] vsel_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [2:0] sel;
  scss_status_t stat;

  assign pin_raw = '{req_l_n: supply_request_low_v_n, req_h_n: supply_request_high_v_n,
    rst: card_reset_input, clk: card_clock_input, cs: chip_select, off_ack: shutdown_ack,
    card_in: card_detect_input, ovc: overcurrent, vcc_ok: vcc_in_range,
    route: card_type_route_select,
    host: {host_extra_line2_i, host_extra_line1_i, host_data_line_i},
    card: {card_extra_line2_i, card_extra_line1_i, card_data_line_i}};

  // Two-stage synchroniser for every pin
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_q <= SCSS_PINS_RST;
      s2_q <= SCSS_PINS_RST;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  // Control inputs latched while select is low
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hold_q <= SCSS_CTL_RST;
    else if (s2_q.cs)
      hold_q <= '{req_l_n: s2_q.req_l_n, req_h_n: s2_q.req_h_n, rst: s2_q.rst, clk: s2_q.clk};
  end
  assign eff = s2_q.cs ? scss_ctl_t'{req_l_n: s2_q.req_l_n, req_h_n: s2_q.req_h_n,
    rst: s2_q.rst, clk: s2_q.clk} : hold_q; // RQ12 RQ13

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      req_l_prev_q <= 1'h1;
      req_h_prev_q <= 1'h1;
    end
    else
    begin
      req_l_prev_q <= eff.req_l_n;
      req_h_prev_q <= eff.req_h_n;
    end
  end

  assign fall_l = req_l_prev_q & ~eff.req_l_n; // RQ20
  assign fall_h = req_h_prev_q & ~eff.req_h_n;
  assign rel = eff.req_l_n & eff.req_h_n;
  assign in_session = (st_q == SCSS_ST_ACT) || (st_q == SCSS_ST_ON);
  assign fault_ev = in_session && (s2_q.ovc || !s2_q.card_in || (ready_q && !s2_q.vcc_ok)
    || s2_q.off_ack); // RQ6 RQ16
  assign chk_hit = (st_q == SCSS_ST_ACT) && (chk_cnt_q == CW'(CHK_CYC - 1));
  assign chk_fail = chk_hit && !ready_q; // RQ22
  assign deact_go = in_session && (rel || fault_ev || chk_fail); // RQ5
  assign start = (st_q == SCSS_ST_OFF) && (fall_l || fall_h) && s2_q.card_in
    && fault_n_q; // RQ4
  assign step_done = ({1'h0, dcnt_q} + 17'h00001) >= {1'h0, t_q[step_q]}; // RQ23

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      SCSS_ST_OFF:
        if (start)
          st_d = SCSS_ST_ACT;
      SCSS_ST_ACT:
        if (deact_go)
          st_d = SCSS_ST_DEACT;
        else if (chk_hit)
          st_d = SCSS_ST_ON;
      SCSS_ST_ON:
        if (deact_go)
          st_d = SCSS_ST_DEACT;
      SCSS_ST_DEACT:
        if (step_q == SCSS_STEP_LAST && step_done)
          st_d = SCSS_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st_q <= SCSS_ST_OFF;
    else
      st_q <= st_d;
  end

  // Activation check timer and voltage window
  always_ff @(posedge clk_sys)
  begin
    if (rst || st_q != SCSS_ST_ACT)
    begin
      chk_cnt_q <= '0;
      win_q <= '0;
    end
    else
    begin
      chk_cnt_q <= chk_cnt_q + CW'(1);
      if (win_q != WW'(SCSS_WIN_CYC))
        win_q <= win_q + WW'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      vsel_q <= SCSS_V_NONE;
    else if (start)
      vsel_q <= (fall_l && fall_h) ? SCSS_V_18 : (fall_l ? SCSS_V_3 : SCSS_V_5); // RQ20
    else if (st_q == SCSS_ST_ACT && win_q != WW'(SCSS_WIN_CYC)
      && ((vsel_q == SCSS_V_3 && fall_h) || (vsel_q == SCSS_V_5 && fall_l)))
      vsel_q <= SCSS_V_18; // RQ20
    else if (st_q == SCSS_ST_OFF)
      vsel_q <= SCSS_V_NONE;
  end

  // Supply settle timer and ready flag
  always_ff @(posedge clk_sys)
  begin
    if (rst || !vcc_on_q || !s2_q.vcc_ok)
    begin
      rdy_cnt_q <= '0;
      ready_q <= 1'h0;
    end
    else if (rdy_cnt_q == RW'(SCSS_RDY_CYC - 1))
      ready_q <= 1'h1; // RQ21
    else
      rdy_cnt_q <= rdy_cnt_q + RW'(1);
  end

  // Deactivation step timer
  always_ff @(posedge clk_sys)
  begin
    if (rst || st_q != SCSS_ST_DEACT)
    begin
      dcnt_q <= '0;
      step_q <= SCSS_STEP_RST;
    end
    else if (step_done)
    begin
      dcnt_q <= '0;
      step_q <= step_q + 2'h1;
    end
    else
      dcnt_q <= dcnt_q + SCSS_TW'(1);
  end

  // Line enables dropped in order
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      vcc_on_q <= 1'h0;
      rst_en_q <= 1'h0;
      clk_en_q <= 1'h0;
      rx_en_q <= 1'h0;
    end
    else if (start)
    begin
      vcc_on_q <= 1'h1;
      rst_en_q <= 1'h1;
      clk_en_q <= 1'h1;
    end
    else if (st_q == SCSS_ST_DEACT && step_done)
    begin
      unique case (step_q)
        SCSS_STEP_RST: rst_en_q <= 1'h0; // RQ7
        SCSS_STEP_CLK: clk_en_q <= 1'h0; // RQ7
        SCSS_STEP_IO: rx_en_q <= 1'h0; // RQ7
        SCSS_STEP_LAST: vcc_on_q <= 1'h0; // RQ7
      endcase
    end
    else if (in_session && ready_q)
      rx_en_q <= 1'h1; // RQ17
  end

  // Fault latch: a new fault wins over the release clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fault_q <= 1'h0;
    else if (fault_ev || chk_fail)
      fault_q <= 1'h1;
    else if (st_q == SCSS_ST_OFF && rel)
      fault_q <= 1'h0;
  end

  // Pin outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fault_n_q <= 1'h0;
      fault_oe_n_q <= 1'h1;
      ready_oe_n_q <= 1'h1;
      card_rst_q <= 1'h0;
      card_clk_q <= 1'h0;
      route_q <= 1'h0;
    end
    else
    begin
      fault_n_q <= s2_q.card_in && !fault_q && !fault_ev && !chk_fail; // RQ9 RQ10
      fault_oe_n_q <= !s2_q.cs; // RQ15
      ready_oe_n_q <= !s2_q.cs; // RQ15
      card_rst_q <= eff.rst && rst_en_q && ready_q; // RQ1 RQ2
      card_clk_q <= eff.clk && clk_en_q && ready_q; // RQ8
      route_q <= s2_q.route; // RQ16
    end
  end

  // Data line arbiters
  scss_line_if lp[3] ();
  for (genvar i = 0; i < 3; i++)
  begin : g_line
    assign lp[i].rx_en = rx_en_q && ready_q;
    assign lp[i].pass_en = s2_q.cs; // RQ14
    assign lp[i].host_i = s2_q.host[i];
    assign lp[i].card_i = s2_q.card[i];
    scss_line_arb u_arb (
      .clk_sys(clk_sys),
      .rst(rst),
      .lp(lp[i])
    );
  end

  // APB slave, one wait state
  assign sel = reg_sel(paddr);
  assign stat = '{pad: '0, step: step_q, state: st_q, vsel: vsel_q, ready: ready_q,
    fault_n: fault_n_q, card_in: s2_q.card_in, rx_en: rx_en_q, vcc_on: vcc_on_q,
    clk_en: clk_en_q, rst_en: rst_en_q, route: route_q};

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && sel == SCSS_SEL_BAD;
      if (psel && penable && !pready_q && !pwrite)
        prdata_q <= (sel == SCSS_SEL_ST) ? 32'(stat) :
          (sel == SCSS_SEL_BAD) ? 32'h00000000 : {16'h0000, t_q[sel[1:0]]};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      for (int k = 0; k < 4; k++)
        t_q[k] <= SCSS_T_RST;
    else if (psel && penable && pready_q && pwrite && !sel[2])
      t_q[sel[1:0]] <= pwdata[SCSS_TW-1:0]; // RQ23
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign card_rst = card_rst_q;
  assign card_clk = card_clk_q;
  assign vcc_enable = vcc_on_q;
  assign vcc_select = vsel_q;
  assign route_usb = route_q;
  assign fault_n_o = fault_n_q;
  assign fault_n_oe_n = fault_oe_n_q;
  assign ready_o = ready_q;
  assign ready_oe_n = ready_oe_n_q;
  assign host_data_line_o = lp[0].host_o;
  assign host_data_line_oe_n = lp[0].host_oe_n;
  assign host_extra_line1_o = lp[1].host_o;
  assign host_extra_line1_oe_n = lp[1].host_oe_n;
  assign host_extra_line2_o = lp[2].host_o;
  assign host_extra_line2_oe_n = lp[2].host_oe_n;
  assign card_data_line_o = lp[0].card_o;
  assign card_data_line_oe_n = lp[0].card_oe_n;
  assign card_extra_line1_o = lp[1].card_o;
  assign card_extra_line1_oe_n = lp[1].card_oe_n;
  assign card_extra_line2_o = lp[2].card_o;
  assign card_extra_line2_oe_n = lp[2].card_oe_n;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_fault_in_session;
    in_session && fault_ev;
  endsequence
  sequence s_deact_entered;
    st_q == SCSS_ST_DEACT && !fault_n_q;
  endsequence

  AST_OFF_LOW: assert property (st_q == SCSS_ST_OFF |-> !card_rst_q && !card_clk_q) // RQ1
    else $error("card lines active outside session");
  AST_WAIT_RDY: assert property (!ready_q |=> !card_rst_q && !card_clk_q) // RQ2
    else $error("card lines moved before ready");
  AST_START_GATE: assert property ($rose(vcc_on_q) // RQ4
    |-> $past(s2_q.card_in) && $past(fault_n_q))
    else $error("activation without card or with fault");
  AST_RELEASE: assert property ((in_session && rel) |=> st_q == SCSS_ST_DEACT) // RQ5
    else $error("release did not start deactivation");
  AST_FAULT_NOW: assert property (s_fault_in_session |=> s_deact_entered) // RQ10
    else $error("fault output and deactivation not together");
  AST_ORDER_CLK: assert property ($fell(clk_en_q) |-> !rst_en_q) // RQ7
    else $error("clock stopped before reset low");
  AST_ORDER_VCC: assert property ($fell(vcc_on_q) |-> !rx_en_q && !clk_en_q) // RQ7
    else $error("supply dropped before lines");
  AST_OUTSIDE: assert property ((st_q == SCSS_ST_OFF && !fault_q)
    |=> fault_n_q == $past(s2_q.card_in)) // RQ9
    else $error("fault output not showing presence");
  AST_CS_HIZ: assert property (!s2_q.cs |=> ready_oe_n_q && fault_oe_n_q) // RQ15
    else $error("outputs driven while select low");
  AST_CS_HOLD: assert property ((!s2_q.cs && !$past(s2_q.cs)) // RQ13
    |-> hold_q == $past(hold_q))
    else $error("held controls changed while select low");
  AST_V18: assert property ((start && fall_l && fall_h) |=> vsel_q == SCSS_V_18) // RQ20
    else $error("both requests did not choose lowest voltage");
  AST_RDY_SETTLE: assert property ($rose(ready_q) // RQ21
    |-> $past(rdy_cnt_q) == RW'(SCSS_RDY_CYC - 1))
    else $error("ready rose before settle time");
  AST_CHK: assert property (chk_fail |=> st_q == SCSS_ST_DEACT && fault_q) // RQ22
    else $error("no emergency deactivation at check");
endmodule
